// >>> src/branch_skip_call_decode.sv
// Execution core for bit, skip, jump, call, return and context instructions.
//
// Overview of operation
// - Bank-0 bit clear writes zero to the chosen bit, one cycle, flags kept.
// - Bank-0 bit set writes one to the chosen bit, flags kept.
// - Compare immediate sets zero and carry from subtraction, skips when equal.
// - Compare memory sets zero and carry from subtraction, skips when equal.
// - Increment to accumulator: memory plus one into accumulator, skip on zero.
// - Increment memory: memory plus one written back, skip on zero.
// - Decrement to accumulator: memory minus one into accumulator, skip on zero.
// - Decrement memory: memory minus one written back, skip on zero.
// - Test bit clear skips when the addressed bit is zero, changes nothing.
// - Test bit set skips when the addressed bit is one, changes nothing.
// - Bank-0 test bit clear skips when the bank-0 bit is zero.
// - Bank-0 test bit set skips when the bank-0 bit is one.
// - Jump loads page bits into PC 15:14 and field into 13:0, two cycles.
// - Call pushes the 16-bit PC plus one then jumps the same way, two cycles.
// - Returns reload PC from the stack in two cycles; interrupt return sets enable.
// - Save copies working registers 080H to 087H into shadows in one cycle.
// - Restore reloads working registers, flags included, in one cycle.
// - Skip instructions take one cycle plus one when the skip happens.
// - Touching the oscillator mode register costs one extra cycle.
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module branch_skip_call_decode (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Program ROM.
	output logic [15:0] rom_addr_o,
	input wire logic [15:0] rom_data_i,
	// Data RAM.
	output branch_skip_pkg::ram_req_s ram_req_o,
	input wire logic [7:0] ram_rdata_i,
	// Hardware stack.
	output branch_skip_pkg::stack_req_s stack_req_o,
	input wire logic [15:0] stack_top_i,
	// Software register port.
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// Status.
	output logic gie_o,
	output logic retire_o,
	output logic squashed_o
);
	branch_skip_pkg::state_e state_r;
	logic [15:0] pc_r;
	logic [15:0] ir_r;
	logic [7:0] acc_r;
	logic [7:0] wreg_r [8];
	logic [7:0] shadow_r [8];
	logic [1:0] page_r;
	logic [3:0] bank_r;
	logic squash_r;
	logic [3:0] wcnt_r;
	logic exec;

	// Decoded fields of the held instruction.
	logic [1:0] grp;
	logic [2:0] op;
	logic [2:0] bsel;
	logic [7:0] adr;
	logic [7:0] mask;
	logic [11:0] ea;
	logic is_wreg;
	logic [7:0] opnd;
	logic [8:0] diff;
	logic [7:0] inc_v;
	logic [7:0] dec_v;
	logic [7:0] flags_cur;

	// Results of the execute step.
	logic mem_access;
	logic wr_en;
	logic [7:0] wr_val;
	logic acc_we;
	logic [7:0] acc_nxt;
	logic flag_we;
	logic [7:0] flag_nxt;
	logic skip;
	logic [15:0] pc_nxt;
	logic extra;
	logic push;
	logic pop;
	logic gie_set;
	logic save;
	logic restore;

	assign exec = (state_r == branch_skip_pkg::ST_EXEC);
	assign grp = ir_r[branch_skip_pkg::GRP_HI:branch_skip_pkg::GRP_LO];
	assign op = ir_r[branch_skip_pkg::OP_HI:branch_skip_pkg::OP_LO];
	assign bsel = ir_r[branch_skip_pkg::BIT_HI:branch_skip_pkg::BIT_LO];
	assign adr = ir_r[branch_skip_pkg::ADR_HI:0];
	assign mask = 8'h01 << bsel;
	assign flags_cur = wreg_r[branch_skip_pkg::FLAG_IDX];

	// Bank-0 forms ignore the bank select; the others use it.
	function automatic logic [11:0] ea_of(input logic [15:0] ins,
		input logic [3:0] bank);
		logic b0;
		b0 = (ins[15:14] == branch_skip_pkg::GRP_BIT) &&
			(ins[13:11] == branch_skip_pkg::OP_B0_CLR ||
			ins[13:11] == branch_skip_pkg::OP_B0_SET ||
			ins[13:11] == branch_skip_pkg::OP_B0_TST_CLR ||
			ins[13:11] == branch_skip_pkg::OP_B0_TST_SET);
		ea_of = {b0 ? 4'h0 : bank, ins[7:0]};
	endfunction

	// Working registers are held here, so their reads bypass the RAM.
	assign ea = ea_of(ir_r, bank_r);
	assign is_wreg = (ea[11:3] == branch_skip_pkg::WREG_BASE_HI);
	assign opnd = (grp == branch_skip_pkg::GRP_ALU &&
		op == branch_skip_pkg::OP_CMP_IMM) ? adr :
		(is_wreg ? wreg_r[ea[2:0]] : ram_rdata_i);
	assign diff = {1'b0, acc_r} - {1'b0, opnd};
	assign inc_v = opnd + 8'h01;
	assign dec_v = opnd - 8'h01;

	// Execute step: all effects of the held instruction in one place.
	always_comb begin
		mem_access = 1'b0;
		wr_en = 1'b0;
		wr_val = opnd;
		acc_we = 1'b0;
		acc_nxt = acc_r;
		flag_we = 1'b0;
		flag_nxt = flags_cur;
		skip = 1'b0;
		pc_nxt = pc_r + 16'h0001;
		extra = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		gie_set = 1'b0;
		save = 1'b0;
		restore = 1'b0;
		if (!squash_r) begin
			unique case (grp)
			branch_skip_pkg::GRP_BIT: begin
				mem_access = (op <= branch_skip_pkg::OP_B0_TST_SET);
				unique case (op)
				branch_skip_pkg::OP_B0_CLR: begin
					wr_en = 1'b1;
					wr_val = opnd & ~mask;
				end
				branch_skip_pkg::OP_B0_SET: begin
					wr_en = 1'b1;
					wr_val = opnd | mask;
				end
				branch_skip_pkg::OP_TST_CLR:
					skip = ((opnd & mask) == 8'h00);
				branch_skip_pkg::OP_TST_SET:
					skip = ((opnd & mask) != 8'h00);
				branch_skip_pkg::OP_B0_TST_CLR:
					skip = ((opnd & mask) == 8'h00);
				branch_skip_pkg::OP_B0_TST_SET:
					skip = ((opnd & mask) != 8'h00);
				default: ;
				endcase
			end
			branch_skip_pkg::GRP_ALU: begin
				mem_access = (op != branch_skip_pkg::OP_CMP_IMM) &&
					(op != branch_skip_pkg::OP_MISC) && (op != 3'h7);
				unique case (op)
				branch_skip_pkg::OP_CMP_IMM,
				branch_skip_pkg::OP_CMP_MEM: begin
					// Carry is set when no borrow occurs.
					flag_we = 1'b1;
					flag_nxt[branch_skip_pkg::FLAG_Z] = (diff[7:0] == 8'h00);
					flag_nxt[branch_skip_pkg::FLAG_C] = ~diff[8];
					skip = (diff[7:0] == 8'h00);
				end
				branch_skip_pkg::OP_INC_ACC: begin
					acc_we = 1'b1;
					acc_nxt = inc_v;
					skip = (inc_v == 8'h00);
				end
				branch_skip_pkg::OP_INC_MEM: begin
					wr_en = 1'b1;
					wr_val = inc_v;
					skip = (inc_v == 8'h00);
				end
				branch_skip_pkg::OP_DEC_ACC: begin
					acc_we = 1'b1;
					acc_nxt = dec_v;
					skip = (dec_v == 8'h00);
				end
				branch_skip_pkg::OP_DEC_MEM: begin
					wr_en = 1'b1;
					wr_val = dec_v;
					skip = (dec_v == 8'h00);
				end
				branch_skip_pkg::OP_MISC: begin
					unique case (ir_r[2:0])
					branch_skip_pkg::MISC_RET,
					branch_skip_pkg::MISC_INTERRUPT_RETURN: begin
						pop = 1'b1;
						pc_nxt = stack_top_i;
						extra = 1'b1;
						gie_set = (ir_r[2:0] == branch_skip_pkg::MISC_INTERRUPT_RETURN);
					end
					branch_skip_pkg::MISC_SAVE: save = 1'b1;
					branch_skip_pkg::MISC_RESTORE:
						restore = 1'b1;
					default: ; // No-operation.
					endcase
				end
				default: ;
				endcase
			end
			branch_skip_pkg::GRP_JMP: begin
				pc_nxt = {page_r, ir_r[branch_skip_pkg::TGT_HI:0]};
				extra = 1'b1;
			end
			branch_skip_pkg::GRP_CALL: begin
				push = 1'b1;
				pc_nxt = {page_r, ir_r[branch_skip_pkg::TGT_HI:0]};
				extra = 1'b1;
			end
			endcase
			// Oscillator mode register accesses stall one cycle.
			if (mem_access && ea == {4'h0, branch_skip_pkg::OSC_MODE_ADDR})
				extra = 1'b1;
		end
	end

	// Instruction cycle sequencer: fetch, ROM latency, decode, RAM read, execute.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_r <= branch_skip_pkg::ST_FETCH;
			wcnt_r <= 4'h0;
		end else begin
			unique case (state_r)
			branch_skip_pkg::ST_FETCH: state_r <= branch_skip_pkg::ST_LOAD;
			branch_skip_pkg::ST_LOAD: state_r <= branch_skip_pkg::ST_DECODE;
			branch_skip_pkg::ST_DECODE: state_r <= branch_skip_pkg::ST_MEMRD;
			branch_skip_pkg::ST_MEMRD: state_r <= branch_skip_pkg::ST_EXEC;
			branch_skip_pkg::ST_EXEC: begin
				// Two-cycle and stalled instructions idle one whole cycle.
				wcnt_r <= branch_skip_pkg::CYCLE_CLKS_M1;
				state_r <= extra ? branch_skip_pkg::ST_WAIT :
					branch_skip_pkg::ST_FETCH;
			end
			branch_skip_pkg::ST_WAIT: begin
				wcnt_r <= wcnt_r - 4'h1;
				if (wcnt_r == 4'h0)
					state_r <= branch_skip_pkg::ST_FETCH;
			end
			endcase
		end
	end

	// Program counter, ROM address and instruction register.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pc_r <= branch_skip_pkg::PC_RST;
			rom_addr_o <= branch_skip_pkg::PC_RST;
			ir_r <= 16'h0000;
		end else begin
			if (state_r == branch_skip_pkg::ST_FETCH)
				rom_addr_o <= pc_r;
			if (state_r == branch_skip_pkg::ST_DECODE)
				ir_r <= rom_data_i;
			if (exec)
				pc_r <= pc_nxt;
		end
	end

	// A taken skip lets the next instruction be fetched but kills it.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i)
			squash_r <= 1'b0;
		else if (exec)
			squash_r <= skip;
	end

	// RAM port: address is registered at the end of decode and stands from the RAM read step, writes at execute.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ram_req_o <= '0;
		end else begin
			ram_req_o.we <= exec && wr_en && !is_wreg;
			if (state_r == branch_skip_pkg::ST_DECODE)
				ram_req_o.addr <= ea_of(rom_data_i, bank_r);
			if (exec)
				ram_req_o.wdata <= wr_val;
		end
	end

	// Stack port: one-cycle push or pop strobes.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			stack_req_o <= '0;
		end else begin
			stack_req_o.push <= exec && push;
			stack_req_o.pop <= exec && pop;
			if (exec && push)
				stack_req_o.data <= pc_r + 16'h0001;
		end
	end

	// Accumulator.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i)
			acc_r <= branch_skip_pkg::ACC_RST;
		else if (exec && acc_we)
			acc_r <= acc_nxt;
	end

	// Working registers: memory writes, flag updates and context restore.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < 8; i++)
				wreg_r[i] <= 8'h00;
		end else if (exec) begin
			if (restore) begin
				for (int i = 0; i < 8; i++)
					wreg_r[i] <= shadow_r[i];
			end else if (wr_en && is_wreg) begin
				wreg_r[ea[2:0]] <= wr_val;
			end else if (flag_we) begin
				wreg_r[branch_skip_pkg::FLAG_IDX] <= flag_nxt;
			end
		end
	end

	// Shadow buffers hold one saved context; a second save overwrites it.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < 8; i++)
				shadow_r[i] <= 8'h00;
		end else if (exec && save) begin
			for (int i = 0; i < 8; i++)
				shadow_r[i] <= wreg_r[i];
		end
	end

	// Global interrupt enable: the interrupt return sets it and wins over a write.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i)
			gie_o <= 1'b0;
		else if (exec && gie_set)
			gie_o <= 1'b1;
		else if (reg_wr_i && reg_addr_i == branch_skip_pkg::REG_CTRL)
			gie_o <= reg_wdata_i[branch_skip_pkg::CTRL_GIE];
	end

	// Software-written page and bank selects.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			page_r <= branch_skip_pkg::PAGE_RST;
			bank_r <= branch_skip_pkg::BANK_RST;
		end else if (reg_wr_i) begin
			if (reg_addr_i == branch_skip_pkg::REG_CTRL)
				page_r <= reg_wdata_i[1:0];
			if (reg_addr_i == branch_skip_pkg::REG_BANK)
				bank_r <= reg_wdata_i[3:0];
		end
	end

	// Read data stands only in the cycle after the strobe; else zero.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 8'h00;
		end else if (!reg_rd_i) begin
			reg_rdata_o <= 8'h00;
		end else begin
			unique case (reg_addr_i)
			branch_skip_pkg::REG_CTRL: reg_rdata_o <= {gie_o, 5'h00, page_r};
			branch_skip_pkg::REG_BANK: reg_rdata_o <= {4'h0, bank_r};
			branch_skip_pkg::REG_ACC: reg_rdata_o <= acc_r;
			branch_skip_pkg::REG_FLAGS: reg_rdata_o <= flags_cur;
			branch_skip_pkg::REG_PC_LO: reg_rdata_o <= pc_r[7:0];
			branch_skip_pkg::REG_PC_HI: reg_rdata_o <= pc_r[15:8];
			branch_skip_pkg::REG_STATUS:
				reg_rdata_o <= {6'h00, squash_r,
					state_r == branch_skip_pkg::ST_WAIT};
			default: reg_rdata_o <= 8'h00;
			endcase
		end
	end

	// Retire pulse at the end of each execute; squashed ones are marked.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			retire_o <= 1'b0;
			squashed_o <= 1'b0;
		end else begin
			retire_o <= exec;
			squashed_o <= exec && squash_r;
		end
	end
endmodule

`default_nettype wire

// >>> src/branch_skip_pkg.sv
// Shared constants, encodings and carriers for the branch and skip core.
`default_nettype none

package branch_skip_pkg;
	// Widths of the program counter, data address and data words.
	localparam int PC_W = 16;
	localparam int AD_W = 12;
	localparam int DW = 8;
	// Clock edges that make up one instruction cycle.
	localparam int CYCLE_CLKS = 5;
	localparam logic [3:0] CYCLE_CLKS_M1 = 4'h4;
	// Instruction word fields.
	localparam int GRP_HI = 15;
	localparam int GRP_LO = 14;
	localparam int OP_HI = 13;
	localparam int OP_LO = 11;
	localparam int BIT_HI = 10;
	localparam int BIT_LO = 8;
	localparam int ADR_HI = 7;
	localparam int TGT_HI = 13;
	// Instruction groups.
	localparam logic [1:0] GRP_BIT = 2'h0;
	localparam logic [1:0] GRP_ALU = 2'h1;
	localparam logic [1:0] GRP_JMP = 2'h2;
	localparam logic [1:0] GRP_CALL = 2'h3;
	// Bit group operations.
	localparam logic [2:0] OP_B0_CLR = 3'h0;
	localparam logic [2:0] OP_B0_SET = 3'h1;
	localparam logic [2:0] OP_TST_CLR = 3'h2;
	localparam logic [2:0] OP_TST_SET = 3'h3;
	localparam logic [2:0] OP_B0_TST_CLR = 3'h4;
	localparam logic [2:0] OP_B0_TST_SET = 3'h5;
	// Arithmetic group operations.
	localparam logic [2:0] OP_CMP_IMM = 3'h0;
	localparam logic [2:0] OP_CMP_MEM = 3'h1;
	localparam logic [2:0] OP_INC_ACC = 3'h2;
	localparam logic [2:0] OP_INC_MEM = 3'h3;
	localparam logic [2:0] OP_DEC_ACC = 3'h4;
	localparam logic [2:0] OP_DEC_MEM = 3'h5;
	localparam logic [2:0] OP_MISC = 3'h6;
	// Miscellaneous selector in the low bits.
	localparam logic [2:0] MISC_NOP = 3'h0;
	localparam logic [2:0] MISC_RET = 3'h1;
	localparam logic [2:0] MISC_INTERRUPT_RETURN = 3'h2;
	localparam logic [2:0] MISC_SAVE = 3'h3;
	localparam logic [2:0] MISC_RESTORE = 3'h4;
	// Working registers, flag register and oscillator mode register.
	localparam logic [8:0] WREG_BASE_HI = 9'h010;
	localparam logic [2:0] FLAG_IDX = 3'h6;
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 2;
	localparam logic [7:0] OSC_MODE_ADDR = 8'hca;
	// Software register port offsets and fields.
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_BANK = 4'h1;
	localparam logic [3:0] REG_ACC = 4'h2;
	localparam logic [3:0] REG_FLAGS = 4'h3;
	localparam logic [3:0] REG_PC_LO = 4'h4;
	localparam logic [3:0] REG_PC_HI = 4'h5;
	localparam logic [3:0] REG_STATUS = 4'h6;
	localparam int CTRL_GIE = 7;
	// Reset values.
	localparam logic [15:0] PC_RST = 16'h0000;
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [1:0] PAGE_RST = 2'h0;
	localparam logic [3:0] BANK_RST = 4'h0;

	typedef enum logic [2:0] {
		ST_FETCH, ST_LOAD, ST_DECODE, ST_MEMRD, ST_EXEC, ST_WAIT
	} state_e;

	typedef struct packed {
		logic [11:0] addr;
		logic [7:0] wdata;
		logic we;
	} ram_req_s;

	typedef struct packed {
		logic push;
		logic pop;
		logic [15:0] data;
	} stack_req_s;
endpackage

`default_nettype wire

// >>> verif/branch_skip_mem_model.sv
// Program ROM, data RAM and hardware stack that sit beside the core.
`timescale 1ns/1ps
`default_nettype none

module branch_skip_mem_model (
	// Clock.
	input wire logic clk_i,
	// Program ROM.
	input wire logic [15:0] rom_addr_i,
	output logic [15:0] rom_data_o,
	// Data RAM.
	input wire branch_skip_pkg::ram_req_s ram_req_i,
	output logic [7:0] ram_rdata_o,
	// Hardware stack.
	input wire branch_skip_pkg::stack_req_s stack_req_i,
	output logic [15:0] stack_top_o
);
	logic [15:0] rom [0:255];
	logic [7:0] ram [0:4095];
	logic [15:0] stk [0:7];
	logic [2:0] sp_r = 3'h0;

	// The ROM repeats every 256 words, so paged targets reach the same image.
	assign rom_data_o = rom[rom_addr_i[7:0]];
	assign ram_rdata_o = ram[ram_req_i.addr];
	assign stack_top_o = stk[sp_r - 3'h1];

	// Writes and stack moves act on the edge that carries their pulse.
	always @(posedge clk_i) begin
		if (ram_req_i.we) begin
			ram[ram_req_i.addr] <= ram_req_i.wdata;
		end
		if (stack_req_i.push) begin
			stk[sp_r] <= stack_req_i.data;
			sp_r <= sp_r + 3'h1;
		end else if (stack_req_i.pop) begin
			sp_r <= sp_r - 3'h1;
		end
	end
endmodule

`default_nettype wire

// >>> verif/branch_skip_properties.sv
// Timing and ordering checks on the ports of the branch and skip core.
`timescale 1ns/1ps
`default_nettype none

module branch_skip_props (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Memories.
	input wire logic [15:0] rom_addr_o,
	input wire branch_skip_pkg::ram_req_s ram_req_o,
	input wire branch_skip_pkg::stack_req_s stack_req_o,
	input wire logic [15:0] stack_top_i,
	// Register port and status.
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic gie_o,
	input wire logic retire_o,
	input wire logic squashed_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	logic [15:0] ret_tgt_r;

	// Remember the popped return address to follow it to the next fetch.
	always_ff @(posedge clk_i) begin
		if (stack_req_o.pop) begin
			ret_tgt_r <= stack_top_i;
		end
	end

	a_retire_gap: assert property (retire_o |=> !retire_o [*4])
		else $error("instruction cycle shorter than five clocks");
	a_write_at_retire: assert property (
		ram_req_o.we |-> retire_o && !squashed_o)
		else $error("memory write outside a live retirement");
	a_stack_at_retire: assert property (
		(stack_req_o.push || stack_req_o.pop) |-> retire_o && !squashed_o)
		else $error("stack move outside a live retirement");
	// A skip that also touches the oscillator mode register idles first.
	a_squash_after_skip: assert property (
		squashed_o |-> retire_o && !$past(squashed_o, 5) &&
		($past(retire_o, 5) || $past(retire_o, 10)))
		else $error("squash not right after a skip");
	a_push_return_pc: assert property (
		stack_req_o.push |-> stack_req_o.data == rom_addr_o + 16'h1)
		else $error("pushed return address wrong");
	a_return_target: assert property (
		stack_req_o.pop |-> ##[1:12] rom_addr_o == ret_tgt_r)
		else $error("return did not fetch from stack top");
	a_fetch_timing: assert property (
		$changed(rom_addr_o) |-> $past(retire_o) || $past(retire_o, 6))
		else $error("fetch address moved at a wrong time");
	a_gie_source: assert property (
		$rose(gie_o) |-> stack_req_o.pop ||
		$past(stack_req_o.pop) || $past(reg_wr_i))
		else $error("interrupt enable rose without cause");
	a_read_quiet: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
		else $error("read data outside the read reply cycle");
endmodule

bind branch_skip_call_decode branch_skip_props i_props (
	.clk_i(clk_i),
	.rst_n_i(rst_n_i),
	.rom_addr_o(rom_addr_o),
	.ram_req_o(ram_req_o),
	.stack_req_o(stack_req_o),
	.stack_top_i(stack_top_i),
	.reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o),
	.gie_o(gie_o),
	.retire_o(retire_o),
	.squashed_o(squashed_o)
);

`default_nettype wire

// >>> verif/branch_skip_call_decode_tb_top.sv
// Self-checking bench that runs a short program through the core.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
	samples_checked++; \
	if ((g) !== (e)) begin \
		failures++; \
		$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); \
	end \
end

module branch_skip_call_decode_tb_top;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [15:0] rom_addr_o;
	logic [15:0] rom_data_i;
	logic [15:0] stack_top_i;
	logic [7:0] ram_rdata_i;
	branch_skip_pkg::ram_req_s ram_req_o;
	branch_skip_pkg::stack_req_s stack_req_o;
	logic [3:0] reg_addr_i;
	logic [7:0] reg_wdata_i;
	logic reg_wr_i;
	logic reg_rd_i;
	logic [7:0] reg_rdata_o;
	logic gie_o;
	logic retire_o;
	logic squashed_o;
	int failures = 0;
	int samples_checked = 0;
	int cyc = 0;
	int n_sq = 0;
	int gap_e = 0;
	int rt[$];
	logic [7:0] d;
	// Bit ops, skips with a victim after each taken one, context save, call and loop.
	logic [15:0] prog [0:26] = '{16'h0320, 16'h0821, 16'h5822, 16'h0823,
		16'h6824, 16'h0923, 16'h5025, 16'h6026, 16'h0a23, 16'h4000,
		16'h0b23, 16'h1427, 16'h0c23, 16'h1c27, 16'h0d23, 16'h2021,
		16'h0e23, 16'h2821, 16'h0f23, 16'h4828, 16'h0823, 16'h7003,
		16'h4001, 16'h7004, 16'h00ca, 16'hc040, 16'h801a};

	always #5 clk_i = ~clk_i;

	branch_skip_call_decode i_dut (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.rom_addr_o(rom_addr_o),
		.rom_data_i(rom_data_i),
		.ram_req_o(ram_req_o),
		.ram_rdata_i(ram_rdata_i),
		.stack_req_o(stack_req_o),
		.stack_top_i(stack_top_i),
		.reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o),
		.gie_o(gie_o),
		.retire_o(retire_o),
		.squashed_o(squashed_o)
	);

	branch_skip_mem_model i_mem (
		.clk_i(clk_i),
		.rom_addr_i(rom_addr_o),
		.rom_data_o(rom_data_i),
		.ram_req_i(ram_req_o),
		.ram_rdata_o(ram_rdata_i),
		.stack_req_i(stack_req_o),
		.stack_top_o(stack_top_i)
	);

	// Sampled on the falling edge so registered pulses have settled.
	always @(negedge clk_i) begin
		cyc++;
		if (retire_o === 1'b1) begin
			rt.push_back(cyc);
		end
		if (squashed_o === 1'b1) begin
			n_sq++;
		end
	end

	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= v;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1 v = reg_rdata_o;
	endtask

	task automatic final_report;
		$display("failures=%0d samples_checked=%0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// A run of a few hundred clocks; twenty thousand means a hang.
	initial begin
		#200000;
		failures++;
		final_report;
	end

	// Main sequence: load memories, reset, run the program, inspect state.
	initial begin
		reg_addr_i = 4'h0;
		reg_wdata_i = 8'h00;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		for (int k = 0; k < 256; k++) i_mem.rom[k] = 16'h7000;
		for (int k = 0; k < 4096; k++) i_mem.ram[k] = 8'h00;
		for (int k = 0; k < 27; k++) i_mem.rom[k] = prog[k];
		i_mem.rom[8'h41] = 16'hc060;
		i_mem.rom[8'h42] = 16'h7002;
		i_mem.rom[8'h60] = 16'h7001;
		i_mem.ram[12'h020] = 8'hff;
		i_mem.ram[12'h122] = 8'hff;
		i_mem.ram[12'h124] = 8'h05;
		i_mem.ram[12'h125] = 8'h10;
		i_mem.ram[12'h126] = 8'h01;
		i_mem.ram[12'h127] = 8'h10;
		repeat (16) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rd(branch_skip_pkg::REG_BANK, d);
		`CHK(d[3:0], branch_skip_pkg::BANK_RST);
		// Bank 1 separates banked operands from the bank-0 forms.
		wr(branch_skip_pkg::REG_BANK, 8'h01);
		wr(branch_skip_pkg::REG_CTRL, 8'h01);
		for (int w = 0; w < 3000 && rt.size() < 32; w++) @(posedge clk_i);
		// Oscillator access, calls, returns and jumps each idle one cycle.
		for (int i = 0; i < 31; i++) begin
			gap_e = (i == 24 || i == 25 || i >= 27) ? 10 : 5;
			`CHK(rt[i+1] - rt[i], gap_e);
		end
		`CHK(n_sq, 6);
		`CHK(i_mem.ram[12'h020], 8'hf7);
		`CHK(i_mem.ram[12'h021], 8'h01);
		`CHK(i_mem.ram[12'h023], 8'h52);
		`CHK(i_mem.ram[12'h122], 8'h00);
		`CHK(i_mem.ram[12'h124], 8'h04);
		`CHK(i_mem.ram[12'h125], 8'h10);
		$display("test program done");
		rd(branch_skip_pkg::REG_ACC, d);
		`CHK(d, 8'h00);
		rd(branch_skip_pkg::REG_FLAGS, d);
		`CHK(d & 8'h05, 8'h05);
		rd(branch_skip_pkg::REG_PC_HI, d);
		`CHK(d, 8'h40);
		rd(branch_skip_pkg::REG_PC_LO, d);
		`CHK(d, 8'h1a);
		rd(branch_skip_pkg::REG_CTRL, d);
		`CHK(d, 8'h81);
		`CHK(gie_o, 1'b1);
		// The accumulator is read-only and offset 0xf is unmapped.
		wr(branch_skip_pkg::REG_ACC, 8'h5a);
		rd(branch_skip_pkg::REG_ACC, d);
		`CHK(d, 8'h00);
		rd(4'hf, d);
		`CHK(d, 8'h00);
		$display("test registers done");
		final_report;
	end
endmodule

`default_nettype wire
